// ---- design/rst_boot_pkg.sv ----
// constants, register map and state type for the reset and boot sequencer
package rst_boot_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned PIN_DRIVE_CYC = 128;
    localparam int unsigned PIN_FILT_VAL = 3;
    localparam int unsigned DRV_CNT_W = $clog2(PIN_DRIVE_CYC + 1);
    localparam logic [3:0] REG_OPTION = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CONTROL = 4'h8;
    localparam int unsigned OPT_FAST_INIT = 5;
    localparam int unsigned OPT_PIN_CFG = 3;
    localparam int unsigned OPT_NMI = 2;
    localparam int unsigned OPT_DIV_HI = 4;
    localparam int unsigned OPT_DIV_LO = 0;
    localparam logic [7:0] OPT_ERASED = 8'hFF;
    localparam logic [1:0] BOOT_DIV8 = 2'h0;
    localparam logic [1:0] BOOT_DIV4 = 2'h1;
    localparam logic [1:0] BOOT_DIV2 = 2'h2;
    localparam logic [2:0] CORE_DIV_8 = 3'h7;
    localparam logic [2:0] CORE_DIV_4 = 3'h3;
    localparam logic [2:0] CORE_DIV_2 = 3'h1;
    localparam logic [2:0] CORE_DIV_1 = 3'h0;
    localparam int unsigned CTRL_SW_RST = 0;
    localparam int unsigned CTRL_CORE_HOLD = 1;
    localparam logic [7:0] VEC_SP_OFS = 8'h00;
    localparam logic [7:0] VEC_PC_OFS = 8'h04;
    localparam logic [31:0] LR_RESET = 32'hFFFF_FFFF;
    localparam int unsigned CLS_POR_ONLY = 0;
    localparam int unsigned CLS_POR_NO_SLEEP = 1;
    localparam int unsigned CLS_CHIP_POR = 2;
    localparam int unsigned CLS_RST_NO_SLEEP = 3;
    localparam int unsigned CLS_EARLY = 4;
    localparam int unsigned CLS_CHIP = 5;
    localparam int unsigned CLS_N = 6;
    typedef enum logic [3:0] {
        ST_POR_HOLD,
        ST_CLKGEN,
        ST_CLK_EN,
        ST_OPT_LOAD,
        ST_FLASH_INIT,
        ST_PIN_WAIT,
        ST_FETCH_SP,
        ST_FETCH_PC,
        ST_RUN
    } seq_state_e;
endpackage

// ---- design/chip_reset_boot_sequencer.sv ----
// reset class generation, reset pin handling and boot sequencing
// Operation
// - power-on source alone asserts power-on-only class; it asserts every other class too
// - power-on or low voltage asserts the class that excludes deep sleep recovery
// - power-on, low voltage or deep sleep wakeup assert the chip power-on class
// - every source except pinless deep sleep wakeup asserts reset-excluding-deep-sleep
// - early chip reset asserts for all sources, releases before flash initialises
// - chip reset releases only after flash init done and pin sensed high
// - drive pin low at least 128 cycles and until flash init done
// - pin config bit 3 zero disables pin until next power-on, no wakeup
// - pin config bit one makes pin dedicated reset, open drain, pulled up, filtered
// - debug reset request resets only debug port registers, nothing else
// - option register loads from option byte, erased value all ones, at each reset
// - option bit 5 clear runs flash init on divided clock, set runs fast
// - option bit 2 clear blocks nonmaskable interrupt; set enables it by default
// - boot divider from bits 4 and 0 sets core divider 7, 3, 1 or 0
// - option bits 7-6 and 1 are reserved and drive nothing
// - exit order: hold reset, start clock generator, enable clocks, release flash
// - option byte read early; divider and flash speed follow it
// - after flash init and pin release, wait pin high, then core clock on
// - fetch stack pointer at offset 0, program counter at 4, link register all ones
// - hold static until supply above threshold and detector reports safe
// - pin filter on low-power ticks: value 3 plus 2-stage sync, 5 ticks
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module chip_reset_boot_sequencer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic src_por,
    input wire logic src_low_voltage,
    input wire logic src_sleep_wake,
    input wire logic src_system,
    input wire logic supply_ok,
    input wire logic lpo_tick,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe,
    input wire logic [7:0] nv_option_byte,
    input wire logic flash_init_done,
    input wire logic debug_subsystem_reset_request,
    input wire logic vec_ack,
    input wire logic [31:0] vec_rdata,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic por_only_rst,
    output logic por_no_sleep_rst,
    output logic chip_por_rst,
    output logic rst_no_sleep,
    output logic early_chip_rst,
    output logic chip_rst,
    output logic debug_port_rst,
    output logic clkgen_en,
    output logic sys_clk_en,
    output logic core_clk_en,
    output logic flash_clk_en,
    output logic [2:0] core_clock_divider,
    output logic nonmaskable_irq_gate,
    output logic pin_reset_dedicated,
    output logic vec_rd,
    output logic [7:0] vec_addr,
    output logic [31:0] cpu_sp,
    output logic [31:0] cpu_pc,
    output logic [31:0] cpu_lr,
    output logic cpu_run
);
    import rst_boot_pkg::*;

    function automatic logic [2:0] boot_div(input logic [1:0] code);
        logic [2:0] d;
        d = CORE_DIV_1;
        if (code == BOOT_DIV8)
            d = CORE_DIV_8;
        else if (code == BOOT_DIV4)
            d = CORE_DIV_4;
        else if (code == BOOT_DIV2)
            d = CORE_DIV_2;
        return d;
    endfunction

    seq_state_e state_r;
    seq_state_e state_nxt;
    logic [CLS_N-1:0] cls_r;
    logic [CLS_N-1:0] cls_set;
    logic [7:0] opt_r;
    logic pin_en_r;
    logic drive_r;
    logic [DRV_CNT_W-1:0] drv_cnt_r;
    logic [1:0] pin_sync_r;
    logic [1:0] pin_lpo_r;
    logic [1:0] filt_cnt_r;
    logic pin_filt_r;
    logic [2:0] fdiv_cnt_r;
    logic core_hold_r;
    logic sw_rst_r;
    logic wait_r;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    wire pin_high = !pin_en_r || pin_filt_r;
    wire ext_pin_src = pin_en_r && !pin_filt_r && (state_r == ST_RUN);
    wire sys_src = src_system || sw_rst_r || ext_pin_src;
    wire any_src = src_por || src_low_voltage || src_sleep_wake || sys_src;
    wire drv_done = (drv_cnt_r >= DRV_CNT_W'(PIN_DRIVE_CYC));
    wire flash_go = flash_init_done && (drv_done || !drive_r);
    wire bus_req = avs_read || avs_write;
    wire bus_take = bus_req && !wait_r;
    wire ctrl_wr = bus_take && avs_write && (avs_address == REG_CONTROL) && avs_byteenable[0];
    wire fast_init = opt_r[OPT_FAST_INIT];

    assign cls_set[CLS_POR_ONLY] = src_por;
    assign cls_set[CLS_POR_NO_SLEEP] = src_por || src_low_voltage;
    assign cls_set[CLS_CHIP_POR] = src_por || src_low_voltage || src_sleep_wake;
    assign cls_set[CLS_RST_NO_SLEEP] = src_por || src_low_voltage || sys_src;
    assign cls_set[CLS_EARLY] = any_src;
    assign cls_set[CLS_CHIP] = any_src;

    assign status_word = {19'h0_0000, flash_init_done, pin_high, drive_r, state_r, cls_r};

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (avs_address == REG_OPTION)
            rd_mux = {24'h00_0000, opt_r};
        else if (avs_address == REG_STATUS)
            rd_mux = status_word;
        else if (avs_address == REG_CONTROL)
            rd_mux = {30'h0000_0000, core_hold_r, 1'b0};
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_POR_HOLD:
                if (supply_ok && !src_por && !src_low_voltage)
                    state_nxt = ST_CLKGEN;
            ST_CLKGEN:
                state_nxt = ST_CLK_EN;
            ST_CLK_EN:
                state_nxt = ST_OPT_LOAD;
            ST_OPT_LOAD:
                state_nxt = ST_FLASH_INIT;
            ST_FLASH_INIT:
                if (flash_go)
                    state_nxt = ST_PIN_WAIT;
            ST_PIN_WAIT:
                if (pin_high && !core_hold_r)
                    state_nxt = ST_FETCH_SP;
            ST_FETCH_SP:
                if (vec_ack)
                    state_nxt = ST_FETCH_PC;
            ST_FETCH_PC:
                if (vec_ack)
                    state_nxt = ST_RUN;
            default:
                state_nxt = ST_RUN;
        endcase
        if (any_src)
            state_nxt = ST_POR_HOLD;
    end

    // pin level: bus-clock synchroniser, then the low-power filter
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pin_sync_r <= 2'h3;
        else
            pin_sync_r <= {pin_sync_r[0], rst_pin_i};
    end

    // filter resets to the negated level so a quiet pin never looks asserted
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_lpo_r <= 2'h3;
            filt_cnt_r <= 2'h0;
            pin_filt_r <= 1'b1;
        end
        else if (lpo_tick)
        begin
            pin_lpo_r <= {pin_lpo_r[0], pin_sync_r[1]};
            if (pin_lpo_r[1] == pin_filt_r)
                filt_cnt_r <= 2'h0;
            else if (filt_cnt_r == 2'(PIN_FILT_VAL - 1))
            begin
                filt_cnt_r <= 2'h0;
                pin_filt_r <= pin_lpo_r[1];
            end
            else
                filt_cnt_r <= filt_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_r <= ST_POR_HOLD;
        else
            state_r <= state_nxt;
    end

    // classes stay latched from the source until their release point
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cls_r <= '1;
        else if (any_src)
            cls_r <= cls_r | cls_set;
        else if (state_r == ST_OPT_LOAD)
            cls_r[CLS_EARLY] <= 1'b0;
        else if (state_r == ST_PIN_WAIT && state_nxt == ST_FETCH_SP)
            cls_r <= '0;
    end

    // the pin is driven even before the option is known; brief contention is accepted
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            drive_r <= 1'b1;
            drv_cnt_r <= '0;
        end
        else if (any_src)
        begin
            drive_r <= drive_r || cls_set[CLS_RST_NO_SLEEP];
            drv_cnt_r <= '0;
        end
        else
        begin
            if (!drv_done)
                drv_cnt_r <= drv_cnt_r + DRV_CNT_W'(1);
            if (state_r == ST_FLASH_INIT && flash_go)
                drive_r <= 1'b0;
        end
    end

    // option byte: taken early, pin setting only on a power-on pass
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            opt_r <= OPT_ERASED;
            pin_en_r <= 1'b1;
        end
        else if (src_por)
            pin_en_r <= 1'b1; // power-on drives the pin before the option is known
        else if (state_r == ST_OPT_LOAD)
        begin
            opt_r <= nv_option_byte;
            if (cls_r[CLS_POR_ONLY])
                pin_en_r <= nv_option_byte[OPT_PIN_CFG];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            clkgen_en <= 1'b0;
            sys_clk_en <= 1'b0;
            core_clk_en <= 1'b0;
            core_clock_divider <= CORE_DIV_1;
        end
        else if (any_src)
        begin
            core_clk_en <= 1'b0;
        end
        else
        begin
            if (state_r == ST_CLKGEN)
                clkgen_en <= 1'b1;
            if (state_r == ST_CLK_EN)
                sys_clk_en <= 1'b1;
            if (state_r == ST_OPT_LOAD)
                core_clock_divider <= boot_div({nv_option_byte[OPT_DIV_HI],
                    nv_option_byte[OPT_DIV_LO]});
            if (state_r == ST_PIN_WAIT && state_nxt == ST_FETCH_SP)
                core_clk_en <= 1'b1;
        end
    end

    // slow init trades recovery time for lower average current
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            fdiv_cnt_r <= 3'h0;
            flash_clk_en <= 1'b0;
        end
        else
        begin
            if (fdiv_cnt_r == 3'h0)
                fdiv_cnt_r <= core_clock_divider;
            else
                fdiv_cnt_r <= fdiv_cnt_r - 3'h1;
            flash_clk_en <= sys_clk_en && (fast_init || fdiv_cnt_r == 3'h0);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            vec_rd <= 1'b0;
            vec_addr <= VEC_SP_OFS;
            cpu_sp <= 32'h0000_0000;
            cpu_pc <= 32'h0000_0000;
            cpu_lr <= LR_RESET;
            cpu_run <= 1'b0;
        end
        else if (any_src)
        begin
            vec_rd <= 1'b0;
            cpu_run <= 1'b0;
        end
        else if (state_nxt == ST_FETCH_SP && state_r == ST_PIN_WAIT)
        begin
            vec_rd <= 1'b1;
            vec_addr <= VEC_SP_OFS;
            cpu_lr <= LR_RESET;
        end
        else if (state_r == ST_FETCH_SP && vec_ack)
        begin
            cpu_sp <= vec_rdata;
            vec_addr <= VEC_PC_OFS;
        end
        else if (state_r == ST_FETCH_PC && vec_ack)
        begin
            cpu_pc <= vec_rdata;
            vec_rd <= 1'b0;
            cpu_run <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            por_only_rst <= 1'b1;
            por_no_sleep_rst <= 1'b1;
            chip_por_rst <= 1'b1;
            rst_no_sleep <= 1'b1;
            early_chip_rst <= 1'b1;
            chip_rst <= 1'b1;
            rst_pin_o <= 1'b0;
            rst_pin_oe <= 1'b1;
            pin_reset_dedicated <= 1'b1;
            nonmaskable_irq_gate <= 1'b1;
            debug_port_rst <= 1'b0;
        end
        else
        begin
            por_only_rst <= cls_r[CLS_POR_ONLY];
            por_no_sleep_rst <= cls_r[CLS_POR_NO_SLEEP];
            chip_por_rst <= cls_r[CLS_CHIP_POR];
            rst_no_sleep <= cls_r[CLS_RST_NO_SLEEP];
            early_chip_rst <= cls_r[CLS_EARLY];
            chip_rst <= cls_r[CLS_CHIP];
            rst_pin_o <= 1'b0; // open drain: only ever pulls low
            rst_pin_oe <= drive_r && pin_en_r;
            pin_reset_dedicated <= pin_en_r;
            nonmaskable_irq_gate <= opt_r[OPT_NMI];
            debug_port_rst <= debug_subsystem_reset_request;
        end
    end

    // bus slave: one wait cycle, then a single low waitrequest cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wait_r <= 1'b1;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            core_hold_r <= 1'b0;
            sw_rst_r <= 1'b0;
        end
        else
        begin
            wait_r <= !(bus_req && wait_r);
            avs_waitrequest <= !(bus_req && wait_r);
            if (bus_req && wait_r)
                avs_readdata <= rd_mux;
            sw_rst_r <= ctrl_wr && avs_writedata[CTRL_SW_RST];
            if (ctrl_wr)
                core_hold_r <= avs_writedata[CTRL_CORE_HOLD];
        end
    end
endmodule

// ---- testbench/rst_boot_props.sv ----
// checker on the sequencer ports: class nesting, pin timing, bus answer, vector fetch
`timescale 1ns/1ps
module rst_boot_props (
    input logic clk_sys,
    input logic rst,
    input logic rst_pin_i,
    input logic rst_pin_oe,
    input logic [7:0] nv_option_byte,
    input logic flash_init_done,
    input logic debug_subsystem_reset_request,
    input logic vec_ack,
    input logic [31:0] vec_rdata,
    input logic avs_read,
    input logic avs_write,
    input logic avs_waitrequest,
    input logic por_only_rst,
    input logic por_no_sleep_rst,
    input logic chip_por_rst,
    input logic rst_no_sleep,
    input logic early_chip_rst,
    input logic chip_rst,
    input logic debug_port_rst,
    input logic [2:0] core_clock_divider,
    input logic nonmaskable_irq_gate,
    input logic pin_reset_dedicated,
    input logic vec_rd,
    input logic [7:0] vec_addr,
    input logic [31:0] cpu_pc,
    input logic [31:0] cpu_lr,
    input logic cpu_run
);
    import rst_boot_pkg::*;
    logic [7:0] drv_cnt_r;
    logic [2:0] div_exp;
    logic div_hi;
    logic div_lo;
    assign div_hi = nv_option_byte[OPT_DIV_HI];
    assign div_lo = nv_option_byte[OPT_DIV_LO];
    assign div_exp = div_hi ? (div_lo ? CORE_DIV_1 : CORE_DIV_2) : (div_lo ? CORE_DIV_4 : CORE_DIV_8);
    // saturating, so a very long hold cannot wrap below the minimum
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst || !rst_pin_oe)
            drv_cnt_r <= 8'h00;
        else if (drv_cnt_r != 8'hFF)
            drv_cnt_r <= drv_cnt_r + 8'h01;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_por_nest: assert property (
        por_only_rst |-> por_no_sleep_rst && chip_por_rst && rst_no_sleep && chip_rst)
        else $error("power-on-only class without the others");
    a_lv_nest: assert property (
        por_no_sleep_rst |-> chip_por_rst && rst_no_sleep && chip_rst)
        else $error("low-voltage class without its followers");
    a_chip_nest: assert property ((chip_por_rst || rst_no_sleep) |-> chip_rst)
        else $error("class asserted without chip reset");
    a_early_first: assert property ($fell(chip_rst) |-> !early_chip_rst)
        else $error("chip reset released before early reset");
    a_pin_min: assert property (
        $fell(rst_pin_oe) && pin_reset_dedicated |->
        drv_cnt_r >= PIN_DRIVE_CYC && $past(flash_init_done))
        else $error("pin released too soon");
    a_chip_wait: assert property (
        $fell(chip_rst) && pin_reset_dedicated |->
        $past(rst_pin_i) && $past(flash_init_done) && !rst_pin_oe)
        else $error("chip reset released with pin low or flash busy");
    a_opt_apply: assert property (
        $rose(cpu_run) |->
        core_clock_divider == div_exp && nonmaskable_irq_gate == nv_option_byte[OPT_NMI])
        else $error("option settings not applied");
    a_fetch_pc: assert property (
        vec_rd && vec_ack && vec_addr == VEC_SP_OFS |=> vec_rd && vec_addr == VEC_PC_OFS)
        else $error("second fetch not at pc offset");
    a_fetch_run: assert property (
        vec_rd && vec_ack && vec_addr == VEC_PC_OFS |=>
        cpu_run && !vec_rd && cpu_pc == $past(vec_rdata) && cpu_lr == LR_RESET)
        else $error("core start state wrong");
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_debug_keep: assert property (
        debug_subsystem_reset_request && cpu_run |=> debug_port_rst && cpu_run && !chip_rst)
        else $error("debug reset disturbed the core");
endmodule
bind chip_reset_boot_sequencer rst_boot_props u_props (.clk_sys, .rst, .rst_pin_i, .rst_pin_oe,
    .nv_option_byte, .flash_init_done, .debug_subsystem_reset_request, .vec_ack, .vec_rdata,
    .avs_read, .avs_write, .avs_waitrequest, .por_only_rst, .por_no_sleep_rst, .chip_por_rst,
    .rst_no_sleep, .early_chip_rst, .chip_rst, .debug_port_rst, .core_clock_divider,
    .nonmaskable_irq_gate, .pin_reset_dedicated, .vec_rd, .vec_addr, .cpu_pc, .cpu_lr, .cpu_run);

// ---- testbench/rst_ext_circuit.sv ----
// open-drain reset wire with pull-up, outside hold and slow rise
`timescale 1ns/1ps
module rst_ext_circuit (
    input logic clk_sys,
    input logic rst_pin_o,
    input logic rst_pin_oe,
    input logic hold_low,
    input logic [7:0] rise_cyc,
    output logic rst_pin_i
);
    logic [7:0] rise_r;
    logic low_pull;
    // pull-up wins only when no party pulls the wire low
    assign low_pull = (rst_pin_oe && !rst_pin_o) || hold_low;
    // a weak pull-up rises slowly after release
    always_ff @(posedge clk_sys)
    begin
        rise_r <= low_pull ? rise_cyc : rise_r - {7'h00, rise_r != 8'h00};
    end
    assign rst_pin_i = !low_pull && rise_r == 8'h00;
endmodule

// ---- testbench/chip_reset_boot_sequencer_bench.sv ----
// self-checking bench for the reset and boot sequencer
`timescale 1ns/1ps
module chip_reset_boot_sequencer_bench;
    import rst_boot_pkg::*;
    localparam logic [31:0] SP_VAL = 32'h2000_0F00;
    localparam logic [31:0] PC_VAL = 32'h0000_01C1;
    logic clk_sys = 1'b0, rst = 1'b1, src_por = 1'b1, src_low_voltage = 1'b0;
    logic src_sleep_wake = 1'b0, src_system = 1'b0, supply_ok = 1'b0, lpo_tick = 1'b0;
    logic flash_init_done = 1'b0, debug_subsystem_reset_request = 1'b0, vec_ack = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, hold_low = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [7:0] nv_option_byte = 8'hFF, rise_cyc = 8'h00, fl_cnt = 8'h00;
    logic [31:0] vec_rdata = 32'h0000_0000, avs_writedata = 32'h0000_0000, rd;
    logic [6:0] cls;
    logic rst_pin_i, rst_pin_o, rst_pin_oe, por_only_rst, por_no_sleep_rst, chip_por_rst;
    logic rst_no_sleep, early_chip_rst, chip_rst, debug_port_rst, clkgen_en, sys_clk_en;
    logic core_clk_en, flash_clk_en, nonmaskable_irq_gate, pin_reset_dedicated, vec_rd;
    logic cpu_run, avs_waitrequest;
    logic [2:0] core_clock_divider;
    logic [7:0] vec_addr;
    logic [31:0] avs_readdata, cpu_sp, cpu_pc, cpu_lr;
    int n_fail = 0, total_checks = 0, cyc = 0;
    chip_reset_boot_sequencer DUT (.clk_sys, .rst, .src_por, .src_low_voltage, .src_sleep_wake,
        .src_system, .supply_ok, .lpo_tick, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .nv_option_byte,
        .flash_init_done, .debug_subsystem_reset_request, .vec_ack, .vec_rdata, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .por_only_rst, .por_no_sleep_rst, .chip_por_rst, .rst_no_sleep, .early_chip_rst,
        .chip_rst, .debug_port_rst, .clkgen_en, .sys_clk_en, .core_clk_en, .flash_clk_en,
        .core_clock_divider, .nonmaskable_irq_gate, .pin_reset_dedicated, .vec_rd, .vec_addr,
        .cpu_sp, .cpu_pc, .cpu_lr, .cpu_run);
    rst_ext_circuit pin_side (.clk_sys, .rst_pin_o, .rst_pin_oe, .hold_low, .rise_cyc,
        .rst_pin_i);
    initial forever #12.5 clk_sys = ~clk_sys;
    // flash, vector memory and low-power ticks; flash is quicker than the pin minimum
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        lpo_tick <= cyc[1:0] == 2'h3;
        fl_cnt <= early_chip_rst ? 8'h00 : fl_cnt + {7'h00, fl_cnt != 8'h14};
        flash_init_done <= !early_chip_rst && fl_cnt == 8'h14;
        vec_ack <= vec_rd && !vec_ack;
        vec_rdata <= (vec_addr == VEC_SP_OFS) ? SP_VAL : PC_VAL;
        if (cyc == 30000)
        begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wait_on(ref logic s, input logic v);
        int k = 0;
        while (s !== v && k < 3000)
        begin
            @(posedge clk_sys);
            k++;
        end
        chk({31'h0, s}, {31'h0, v});
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= wr ? 4'h1 : 4'hF;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic boot();
        wait_on(cpu_run, 1'b1);
        chk(cpu_sp, SP_VAL);
        chk(cpu_pc, PC_VAL);
        chk(cpu_lr, LR_RESET);
    endtask
    // sources held four cycles, classes captured while held
    task automatic kick(input logic [3:0] s);
        {src_por, src_low_voltage, src_sleep_wake, src_system} <= s;
        step(4);
        cls = {rst_pin_oe, por_only_rst, por_no_sleep_rst, chip_por_rst, rst_no_sleep,
            early_chip_rst, chip_rst};
        {src_por, src_low_voltage, src_sleep_wake, src_system} <= 4'h0;
        boot();
    endtask
    task automatic t_power_on();
        src_por <= 1'b0;
        step(40);
        chk({31'h0, clkgen_en}, 32'h0);
        supply_ok <= 1'b1;
        wait_on(clkgen_en, 1'b1);
        chk({30'h0, sys_clk_en, early_chip_rst}, 32'h1);
        wait_on(early_chip_rst, 1'b0);
        chk({30'h0, sys_clk_en, chip_rst}, 32'h3);
        boot();
        chk({29'h0, core_clock_divider}, {29'h0, CORE_DIV_1});
        chk({30'h0, nonmaskable_irq_gate, pin_reset_dedicated}, 32'h3);
        $display("test power_on ended");
    endtask
    task automatic t_regs();
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0000_1A00);
        bus(1'b1, REG_OPTION, 32'h0);
        bus(1'b0, REG_OPTION, 32'h0);
        chk(rd, {24'h0, OPT_ERASED});
        bus(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, REG_CONTROL, 32'h3);
        step(300);
        chk({29'h0, chip_rst, rst_pin_oe, rst_pin_o}, 32'h4);
        bus(1'b0, REG_CONTROL, 32'h0);
        chk(rd, 32'h2);
        bus(1'b1, REG_CONTROL, 32'h0);
        boot();
        $display("test regs ended");
    endtask
    task automatic t_sources();
        kick(4'h4);
        chk({25'h0, cls}, 32'h5F);
        kick(4'h2);
        chk({25'h0, cls}, 32'h0B);
        kick(4'h8);
        chk({25'h0, cls}, 32'h7F);
        kick(4'h1);
        chk({25'h0, cls}, 32'h47);
        $display("test sources ended");
    endtask
    task automatic t_div();
        logic [2:0] dv[4] = '{CORE_DIV_8, CORE_DIV_4, CORE_DIV_2, CORE_DIV_1};
        logic [7:0] nv;
        int n;
        for (int i = 0; i < 5; i++)
        begin
            nv = (i == 4) ? OPT_ERASED : {3'h6, i[1], 1'b1, i[0], 1'b1, i[0]};
            nv_option_byte <= nv;
            kick(4'h1);
            n = 0;
            repeat (16)
            begin
                @(posedge clk_sys);
                n += flash_clk_en;
            end
            chk(32'(n), (i == 4) ? 32'h10 : 32'(16 / (dv[i] + 1)));
            chk({29'h0, core_clock_divider}, {29'h0, (i == 4) ? CORE_DIV_1 : dv[i]});
            chk({31'h0, nonmaskable_irq_gate}, {31'h0, nv[OPT_NMI]});
            bus(1'b0, REG_OPTION, 32'h0);
            chk(rd, {24'h0, nv});
        end
        $display("test div ended");
    endtask
    task automatic t_hold();
        int k = 0;
        rise_cyc <= 8'h0A;
        hold_low <= 1'b1;
        src_system <= 1'b1;
        step(4);
        src_system <= 1'b0;
        while (rst_pin_oe !== 1'b0 && k < 1000)
        begin
            @(posedge clk_sys);
            k++;
        end
        chk({31'h0, k >= PIN_DRIVE_CYC}, 32'h1);
        chk({31'h0, flash_init_done}, 32'h1);
        step(200);
        chk({30'h0, chip_rst, core_clk_en}, 32'h2);
        hold_low <= 1'b0;
        boot();
        rise_cyc <= 8'h00;
        $display("test hold ended");
    endtask
    task automatic t_pin_off();
        nv_option_byte <= 8'hF7;
        kick(4'h8);
        chk({31'h0, pin_reset_dedicated}, 32'h0);
        hold_low <= 1'b1;
        step(100);
        chk({31'h0, cpu_run}, 32'h1);
        hold_low <= 1'b0;
        nv_option_byte <= OPT_ERASED;
        kick(4'h1);
        chk({31'h0, pin_reset_dedicated}, 32'h0);
        kick(4'h8);
        chk({31'h0, pin_reset_dedicated}, 32'h1);
        $display("test pin_off ended");
    endtask
    task automatic t_debug();
        debug_subsystem_reset_request <= 1'b1;
        step(3);
        chk({29'h0, debug_port_rst, cpu_run, chip_rst}, 32'h6);
        debug_subsystem_reset_request <= 1'b0;
        step(3);
        chk({31'h0, debug_port_rst}, 32'h0);
        $display("test debug ended");
    endtask
    initial
    begin
        step(20);
        rst <= 1'b0;
        t_power_on();
        t_regs();
        t_sources();
        t_div();
        t_hold();
        t_pin_off();
        t_debug();
        end_sim();
    end
endmodule
